// ---- hw/pmwc_pkg.sv ----
// constants and types of the power mode wake controller
package pmwc_pkg;

    // crystal and derived rates
    localparam int XTAL_HZ       = 32768;
    localparam int DEB_HZ        = 32;
    localparam int DEB_DIV       = XTAL_HZ / DEB_HZ;
    localparam int DEB_BITS      = $clog2(DEB_DIV);
    localparam int BLINK_BIT     = $clog2(XTAL_HZ) - 1;
    localparam int XDIV_W        = BLINK_BIT + 1;

    // reset hold in crystal cycles
    localparam int BOOT_HOLD     = 4100;
    localparam int NOPWR_HOLD    = 2;

    // wake timer units in ms, converted to crystal cycles
    localparam longint UNIT_SHORT_MS = 2500;
    localparam longint UNIT_LONG_MS  = 60000;
    localparam int UNIT_SHORT = int'(UNIT_SHORT_MS * XTAL_HZ / 1000);
    localparam int UNIT_LONG  = int'(UNIT_LONG_MS * XTAL_HZ / 1000);

    // pin synchroniser slots
    localparam int NSYNC         = 5;
    localparam int S_RST         = 0;
    localparam int S_PWR         = 1;
    localparam int S_BAT         = 2;
    localparam int S_BTN         = 3;
    localparam int S_XTAL        = 4;

    // register byte offsets
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_SEG  = 12'h008;

    // control fields
    localparam int C_HALT        = 0;
    localparam int C_DISP        = 1;
    localparam int C_ARM         = 2;
    localparam int C_UNIT        = 3;
    localparam int C_PRD         = 4;
    localparam int PRD_W         = 3;
    localparam int C_CONV        = 8;
    localparam int C_CMP         = 9;
    localparam int CTRL_W        = 10;

    // status fields
    localparam int F_MODE        = 0;
    localparam int F_PLL         = 2;
    localparam int F_RUN         = 3;
    localparam int F_BTN         = 4;
    localparam int F_TMR         = 5;
    localparam int F_RISE        = 6;
    localparam int F_FALL        = 7;
    localparam int F_BAT         = 8;

    // segment store
    localparam int SEG_W         = 4;
    localparam int SEG_B         = 4;

    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [SEG_W-1:0]  SEG_RST  = 4'h0;

    typedef enum logic [1:0] {
        PMWC_MISSION = 2'b00,
        PMWC_BATTERY = 2'b01,
        PMWC_DISPLAY = 2'b11,
        PMWC_HALT    = 2'b10
    } pmwc_mode_t;

    typedef enum logic [1:0] {
        PMWC_BTN_IDLE = 2'b00,
        PMWC_BTN_SEEN = 2'b01,
        PMWC_BTN_HELD = 2'b11
    } pmwc_btn_t;

    typedef enum logic [1:0] {
        PMWC_R_CTRL = 2'b00,
        PMWC_R_STAT = 2'b01,
        PMWC_R_SEG  = 2'b11,
        PMWC_R_NONE = 2'b10
    } pmwc_reg_t;

endpackage

// ---- hw/pmwc_top.sv ----
// power mode and wake controller with apb register port
// How it works
// - display mode keeps segments, blinks both pins
// - display exits on power, timer, button
// - halt keeps only crystal; same three exits
// - reset pin stops logic, clears all config
// - boot holds 4100 crystal cycles, then runs
// - without system power boot holds two cycles
// - power fall clears pll flag, battery mode
// - power return waits 4100 cycles before mission
// - power fall, weak battery: drop permit, halt
// - pll rise in battery: mission, flag, keep config
// - wake from display/halt clears config
// - watchdog enabled in mission mode
// - button or timer wakes display/halt to battery
// - button edge raises permit and sets flag
// - button debounced by 32 Hz state machine
// - further edges ignored until flag cleared
// - timer expiry raises permit and sets flag
// - timer unit one minute or 2.5 s, 1..7 units
// - arming presets timer; request starts it
// - timer disarmed on every wake
// - converter and compute enables zero without pll
// - weak battery in battery mode forces halt
`timescale 1ns/1ps
module pmwc_top
    import pmwc_pkg::*;
#(
    parameter int BOOT_HOLD_CYC  = BOOT_HOLD,
    parameter int UNIT_SHORT_CYC = UNIT_SHORT,
    parameter int UNIT_LONG_CYC  = UNIT_LONG
)(
    input  wire logic        clk_sys,             // 40 MHz system clock
    input  wire logic        rstn,                // async reset, low
    input  wire logic [11:0] paddr,               // apb address
    input  wire logic        psel,                // apb select
    input  wire logic        penable,             // apb enable
    input  wire logic        pwrite,              // apb direction
    input  wire logic [31:0] pwdata,              // apb write data
    output logic      [31:0] prdata,              // apb read data
    output logic             pready,              // apb ready
    output logic             pslverr,             // apb error
    input  wire logic        ext_reset_pin,       // reset pin, high
    input  wire logic        power_sense_input,   // high: above fault_threshold
    input  wire logic        battery_margin_good, // regulator margin ok
    input  wire logic        pushbutton_input,    // button, high pressed
    input  wire logic        xtal_clk_in,         // 32768 Hz crystal
    output logic             run_permit,          // mpu out of reset
    output logic             pll_ok,              // pll stable flag
    output logic             battery_run_mode,    // in battery mode
    output logic      [1:0]  mode_state,          // current mode
    output logic             watchdog_enable,     // hw watchdog on
    output logic             converter_enable,    // adc enable
    output logic             compute_enable,      // compute engine enable
    output logic             pll_rise_event,      // pll rise pulse
    output logic [SEG_W-1:0] blink_segment_pin_a, // blink pin a
    output logic [SEG_W-1:0] blink_segment_pin_b  // blink pin b
);

    localparam int HOLD_W = $clog2(BOOT_HOLD_CYC + 1);
    localparam int UNIT_W = $clog2(UNIT_LONG_CYC + 1);

    if (BOOT_HOLD_CYC < NOPWR_HOLD || UNIT_SHORT_CYC < 1
        || UNIT_LONG_CYC < UNIT_SHORT_CYC)
    begin : g_chk
        $error("pmwc_top: bad hold or unit count");
    end

    function automatic pmwc_reg_t reg_of(input logic [11:0] a);
        unique case (a)
            A_CTRL:  reg_of = PMWC_R_CTRL;
            A_STAT:  reg_of = PMWC_R_STAT;
            A_SEG:   reg_of = PMWC_R_SEG;
            default: reg_of = PMWC_R_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and crystal ticks

    logic [NSYNC-1:0]  sync1_q, sync2_q, prev_q;
    logic [XDIV_W-1:0] xdiv_q;
    logic              xtal_tick, deb_tick, rst_s, pwr_s, bat_s, btn_s;
    logic              rst_rel, pwr_rise, pwr_fall;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end
        else
        begin
            sync1_q <= {xtal_clk_in, pushbutton_input, battery_margin_good,
                        power_sense_input, ext_reset_pin};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rst_s     = sync2_q[S_RST];
    assign pwr_s     = sync2_q[S_PWR];
    assign bat_s     = sync2_q[S_BAT];
    assign btn_s     = sync2_q[S_BTN];
    assign xtal_tick = sync2_q[S_XTAL] & ~prev_q[S_XTAL];
    assign rst_rel   = prev_q[S_RST] & ~rst_s;
    assign pwr_rise  = ~prev_q[S_PWR] & pwr_s & ~rst_s;
    assign pwr_fall  = prev_q[S_PWR] & ~pwr_s & ~rst_s;
    assign deb_tick  = xtal_tick && (xdiv_q[DEB_BITS-1:0] == '1);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            xdiv_q <= '0;
        else if (xtal_tick)
            xdiv_q <= xdiv_q + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave

    pmwc_reg_t        sel;
    logic             wr, wr_ctrl, wr_stat;
    logic [CTRL_W-1:0] ctrl_q;
    logic [SEG_W-1:0] seg_a_q, seg_b_q;
    logic [31:0]      rdata_q, rd_d;
    logic             ready_q, err_q;
    pmwc_mode_t       mode_q;
    logic             permit_q, pll_q, btn_flag_q, tmr_flag_q;
    logic             rise_flag_q, fall_flag_q;

    assign sel     = reg_of(paddr);
    assign wr      = psel & penable & pwrite & ready_q;
    assign wr_ctrl = wr && sel == PMWC_R_CTRL;
    assign wr_stat = wr && sel == PMWC_R_STAT;

    always_comb
    begin
        rd_d = '0;
        unique case (sel)
            PMWC_R_CTRL:
            begin
                rd_d[CTRL_W-1:0] = ctrl_q;
                rd_d[C_CONV]     = ctrl_q[C_CONV] & pll_q;
                rd_d[C_CMP]      = ctrl_q[C_CMP] & pll_q;
            end
            PMWC_R_STAT:
            begin
                rd_d[F_MODE+1:F_MODE] = mode_q;
                rd_d[F_PLL]  = pll_q;
                rd_d[F_RUN]  = permit_q;
                rd_d[F_BTN]  = btn_flag_q;
                rd_d[F_TMR]  = tmr_flag_q;
                rd_d[F_RISE] = rise_flag_q;
                rd_d[F_FALL] = fall_flag_q;
                rd_d[F_BAT]  = bat_s;
            end
            PMWC_R_SEG:  rd_d[2*SEG_W-1:0] = {seg_b_q, seg_a_q};
            PMWC_R_NONE: rd_d = '0;
        endcase
    end

    // answer is prepared in setup, ready in the access cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_q <= '0;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end
        else
        begin
            ready_q <= psel & ~penable;
            if (psel & ~penable)
            begin
                rdata_q <= pwrite ? '0 : rd_d;
                err_q   <= (sel == PMWC_R_NONE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration: control cleared while the mpu is held off, segments only by the reset pin

    logic req_halt, req_disp, arm_wr;

    assign req_halt = wr_ctrl & pwdata[C_HALT] & (mode_q == PMWC_BATTERY);
    assign req_disp = wr_ctrl & pwdata[C_DISP] & (mode_q == PMWC_BATTERY);
    assign arm_wr   = wr_ctrl & pwdata[C_ARM] & permit_q;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            ctrl_q <= CTRL_RST;
        else if (rst_s || !permit_q)
            ctrl_q <= CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= pwdata[CTRL_W-1:0];
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            seg_a_q <= SEG_RST;
            seg_b_q <= SEG_RST;
        end
        else if (rst_s)
        begin
            seg_a_q <= SEG_RST;
            seg_b_q <= SEG_RST;
        end
        else if (wr && sel == PMWC_R_SEG)
        begin
            seg_a_q <= pwdata[SEG_W-1:0];
            seg_b_q <= pwdata[SEG_B+SEG_W-1:SEG_B];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // settle counter for boot and power return

    logic              settle_q, boot_q, settle_done;
    logic [HOLD_W-1:0] hold_q;

    assign settle_done = settle_q && xtal_tick && hold_q == HOLD_W'(1);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            settle_q <= 1'b0;
            boot_q   <= 1'b0;
            hold_q   <= '0;
        end
        else if (rst_s)
        begin
            settle_q <= 1'b0;
            boot_q   <= 1'b0;
            hold_q   <= '0;
        end
        else if (rst_rel)
        begin
            settle_q <= 1'b1;
            boot_q   <= 1'b1;
            hold_q   <= pwr_s ? HOLD_W'(BOOT_HOLD_CYC)
                              : HOLD_W'(NOPWR_HOLD);
        end
        else if (pwr_rise)
        begin
            settle_q <= 1'b1;
            boot_q   <= 1'b0;
            hold_q   <= HOLD_W'(BOOT_HOLD_CYC);
        end
        else if (pwr_fall)
        begin
            settle_q <= boot_q;
            hold_q   <= HOLD_W'(NOPWR_HOLD);
        end
        else if (settle_done)
        begin
            settle_q <= 1'b0;
            boot_q   <= 1'b0;
        end
        else if (settle_q && xtal_tick)
            hold_q <= hold_q - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // pushbutton debounce on the 32 Hz tick

    pmwc_btn_t btn_q;
    logic      btn_evt;

    assign btn_evt = deb_tick & (btn_q == PMWC_BTN_SEEN) & btn_s
                     & ~btn_flag_q;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            btn_q <= PMWC_BTN_IDLE;
        else if (rst_s)
            btn_q <= PMWC_BTN_IDLE;
        else if (deb_tick)
        begin
            unique case (btn_q)
                PMWC_BTN_IDLE: btn_q <= btn_s ? PMWC_BTN_SEEN : PMWC_BTN_IDLE;
                PMWC_BTN_SEEN: btn_q <= btn_s ? PMWC_BTN_HELD : PMWC_BTN_IDLE;
                PMWC_BTN_HELD: btn_q <= btn_s ? PMWC_BTN_HELD : PMWC_BTN_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wake timer

    logic              armed_q, long_q, tmr_exp, asleep, wake;
    logic [PRD_W-1:0]  prd_q;
    logic [UNIT_W-1:0] sub_q, unit_cyc;

    assign asleep   = (mode_q == PMWC_DISPLAY) || (mode_q == PMWC_HALT);
    assign unit_cyc = long_q ? UNIT_W'(UNIT_LONG_CYC) : UNIT_W'(UNIT_SHORT_CYC);
    assign tmr_exp  = armed_q && asleep && !permit_q && xtal_tick
                      && sub_q == UNIT_W'(1) && prd_q == PRD_W'(1);
    assign wake     = asleep && bat_s && (btn_evt || tmr_exp);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            armed_q <= 1'b0;
            long_q  <= 1'b0;
            prd_q   <= '0;
            sub_q   <= '0;
        end
        else if (rst_s || wake || tmr_exp || settle_done)
            armed_q <= 1'b0;
        else if (arm_wr)
        begin
            armed_q <= pwdata[C_PRD+PRD_W-1:C_PRD] != '0;
            long_q  <= pwdata[C_UNIT];
            prd_q   <= pwdata[C_PRD+PRD_W-1:C_PRD];
            sub_q   <= pwdata[C_UNIT] ? UNIT_W'(UNIT_LONG_CYC)
                                      : UNIT_W'(UNIT_SHORT_CYC);
        end
        else if (armed_q && asleep && !permit_q && xtal_tick)
        begin
            if (sub_q == UNIT_W'(1))
            begin
                sub_q <= unit_cyc;
                prd_q <= prd_q - 1'b1;
            end
            else
                sub_q <= sub_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode machine

    logic pll_rise;

    assign pll_rise = settle_done && pwr_s && mode_q == PMWC_BATTERY && !boot_q;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_q   <= PMWC_MISSION;
            permit_q <= 1'b0;
            pll_q    <= 1'b0;
        end
        else if (rst_s)
        begin
            permit_q <= 1'b0;
            pll_q    <= 1'b0;
        end
        else if (settle_done)
        begin
            // mission needs a stable pll; otherwise boot to battery
            pll_q    <= pwr_s;
            mode_q   <= pwr_s ? PMWC_MISSION : PMWC_BATTERY;
            permit_q <= 1'b1;
        end
        else if (pwr_fall)
        begin
            pll_q <= 1'b0;
            if (!asleep && bat_s)
                mode_q <= PMWC_BATTERY;
            else if (!bat_s)
            begin
                mode_q   <= PMWC_HALT;
                permit_q <= 1'b0;
            end
        end
        else
        begin
            unique case (mode_q)
                PMWC_MISSION: mode_q <= PMWC_MISSION;
                PMWC_BATTERY:
                begin
                    if (!bat_s || req_halt)
                    begin
                        mode_q   <= PMWC_HALT;
                        permit_q <= 1'b0;
                    end
                    else if (req_disp)
                    begin
                        mode_q   <= PMWC_DISPLAY;
                        permit_q <= 1'b0;
                    end
                end
                PMWC_DISPLAY, PMWC_HALT:
                begin
                    if (wake)
                    begin
                        mode_q   <= PMWC_BATTERY;
                        permit_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event flags, write one to clear, set wins

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            btn_flag_q  <= 1'b0;
            tmr_flag_q  <= 1'b0;
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
        end
        else if (rst_s)
        begin
            btn_flag_q  <= 1'b0;
            tmr_flag_q  <= 1'b0;
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
        end
        else
        begin
            btn_flag_q  <= btn_evt | (btn_flag_q & ~(wr_stat & pwdata[F_BTN]));
            tmr_flag_q  <= tmr_exp | (tmr_flag_q & ~(wr_stat & pwdata[F_TMR]));
            rise_flag_q <= pll_rise | (rise_flag_q & ~(wr_stat & pwdata[F_RISE]));
            fall_flag_q <= (pwr_fall & (mode_q == PMWC_MISSION))
                           | (fall_flag_q & ~(wr_stat & pwdata[F_FALL]));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs

    logic              wdog_q, conv_q, cmp_q, rise_q, batm_q;
    logic [SEG_W-1:0]  pin_a_q, pin_b_q;
    logic              pll_drop;

    // enables fall with the pll flag, not a cycle after it
    assign pll_drop = rst_s | pwr_fall | (settle_done & ~pwr_s);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            wdog_q  <= 1'b0;
            conv_q  <= 1'b0;
            cmp_q   <= 1'b0;
            rise_q  <= 1'b0;
            batm_q  <= 1'b0;
            pin_a_q <= '0;
            pin_b_q <= '0;
        end
        else
        begin
            wdog_q <= permit_q && mode_q == PMWC_MISSION;
            conv_q <= ctrl_q[C_CONV] & pll_q & ~pll_drop;
            cmp_q  <= ctrl_q[C_CMP] & pll_q & ~pll_drop;
            rise_q <= pll_rise;
            batm_q <= permit_q && mode_q == PMWC_BATTERY;
            if (rst_s || mode_q == PMWC_HALT)
            begin
                pin_a_q <= '0;
                pin_b_q <= '0;
            end
            else
            begin
                pin_a_q <= seg_a_q & {SEG_W{xdiv_q[BLINK_BIT]}};
                pin_b_q <= seg_b_q & {SEG_W{xdiv_q[BLINK_BIT]}};
            end
        end
    end

    assign prdata              = rdata_q;
    assign pready              = ready_q;
    assign pslverr             = err_q;
    assign run_permit          = permit_q;
    assign pll_ok              = pll_q;
    assign battery_run_mode    = batm_q;
    assign mode_state          = mode_q;
    assign watchdog_enable     = wdog_q;
    assign converter_enable    = conv_q;
    assign compute_enable      = cmp_q;
    assign pll_rise_event      = rise_q;
    assign blink_segment_pin_a = pin_a_q;
    assign blink_segment_pin_b = pin_b_q;

endmodule // pmwc_top

// ---- sim/pmwc_checker.sv ----
// port assertions for the power mode wake controller
`timescale 1ns/1ps
module pmwc_checker
    import pmwc_pkg::*;
(
    input wire logic             clk_sys,           // clock
    input wire logic             rstn,              // reset
    input wire logic             ext_reset_pin,     // pin
    input wire logic             power_sense_input, // supply
    input wire logic             run_permit,        // run
    input wire logic             pll_ok,            // pll
    input wire logic             battery_run_mode,  // battery
    input wire logic [1:0]       mode_state,        // mode
    input wire logic             watchdog_enable,   // dog
    input wire logic             converter_enable,  // adc
    input wire logic             compute_enable,    // ce
    input wire logic             pll_rise_event,    // rise
    input wire logic [SEG_W-1:0] blink_segment_pin_a, // pin a
    input wire logic [SEG_W-1:0] blink_segment_pin_b  // pin b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // inputs pass a synchroniser, so allow for its delay
    sequence s_pin_held; ext_reset_pin [*5]; endsequence
    sequence s_power_gone; !power_sense_input [*6]; endsequence
    a_pin_stops: assert property (s_pin_held |-> !run_permit && !pll_ok)
        else $error("reset pin ignored");
    a_fault_clears: assert property (s_power_gone |-> !pll_ok)
        else $error("pll flag kept without power");
    a_enables_gated: assert property ((converter_enable || compute_enable) |-> pll_ok)
        else $error("enable without pll");
    a_dog_mission: assert property (watchdog_enable |->
        mode_state == PMWC_MISSION || $past(mode_state) == PMWC_MISSION)
        else $error("watchdog outside mission");
    a_dog_armed: assert property ((mode_state == PMWC_MISSION && run_permit) [*2]
        |-> watchdog_enable)
        else $error("watchdog off in mission");
    a_halt_dark: assert property ((mode_state == PMWC_HALT) [*2] |-> !run_permit
        && blink_segment_pin_a == 4'h0 && blink_segment_pin_b == 4'h0)
        else $error("activity in halt");
    a_display_stops: assert property ((mode_state == PMWC_DISPLAY) [*2]
        |-> !run_permit && !battery_run_mode)
        else $error("mpu runs in display mode");
    a_rise_mission: assert property (pll_rise_event
        |-> ##[0:1] (mode_state == PMWC_MISSION && pll_ok && run_permit))
        else $error("pll rise without mission");
    a_wake_battery: assert property ($rose(run_permit) && !pll_ok && $past(mode_state[1])
        |-> ##[0:1] mode_state == PMWC_BATTERY)
        else $error("wake not into battery mode");
    a_mission_pll: assert property (mode_state == PMWC_MISSION && run_permit |-> pll_ok)
        else $error("mission without pll");
endmodule // pmwc_checker

// ---- sim/pmwc_far_model.sv ----
// crystal, supply, battery and pushbutton around the controller
`timescale 1ns/1ps
module pmwc_far_model
(
    input  wire logic clk_sys,             // clock
    input  wire logic pwr_req,             // supply wanted
    input  wire logic bat_req,             // margin wanted
    input  wire logic press_req,           // button held
    output logic      xtal_clk_in,         // crystal
    output logic      power_sense_input,   // comparator
    output logic      battery_margin_good, // regulator
    output logic      pushbutton_input     // button pin
);
    logic [1:0] xdiv_q   = 2'h0;
    logic [3:0] bounce_q = 4'h0;
    logic       pwr_q    = 1'b0;
    logic       bat_q    = 1'b1;
    // oscillator free-runs; contacts chatter early in a press
    always @(posedge clk_sys)
    begin
        xdiv_q   <= xdiv_q + 2'h1;
        pwr_q    <= pwr_req;
        bat_q    <= bat_req;
        bounce_q <= press_req ? bounce_q + {3'h0, ~&bounce_q} : 4'h0;
    end
    assign xtal_clk_in         = xdiv_q[1];
    assign power_sense_input   = pwr_q;
    assign battery_margin_good = bat_q;
    assign pushbutton_input    = press_req && (&bounce_q || bounce_q[0]);
endmodule // pmwc_far_model

// ---- sim/pmwc_top_test.sv ----
// self-checking bench for the power mode wake controller
`timescale 1ns/1ps
module pmwc_top_test
    import pmwc_pkg::*;
;
    localparam int TK = 4;
    logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic ext_reset_pin = 1'b0, pwr_req = 1'b0, bat_req = 1'b1, press_req = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic pready, pslverr, err_q, xtal_clk_in, power_sense_input;
    logic battery_margin_good, pushbutton_input, run_permit, pll_ok;
    logic battery_run_mode, watchdog_enable, converter_enable, compute_enable;
    logic pll_rise_event;
    logic [1:0] mode_state;
    logic [SEG_W-1:0] blink_segment_pin_a, blink_segment_pin_b;
    int error_cnt = 0, num_checks = 0, cyc = 0, seed = 32'h3afd9ba8, p, per, c;
    pmwc_top #(.BOOT_HOLD_CYC(8), .UNIT_SHORT_CYC(4), .UNIT_LONG_CYC(8)) pmwc_top_inst (.*);
    pmwc_far_model pmwc_far_model_inst (.*);
    initial forever #12.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd_q  = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clk_sys);
    endtask
    function automatic logic [3:0] st_exp(input pmwc_mode_t m);
        return {m == PMWC_MISSION || m == PMWC_BATTERY, m == PMWC_MISSION, m};
    endfunction
    task automatic stat(input pmwc_mode_t m);
        apb(1'b0, A_STAT, 32'h0);
        chk("status", rd_q & 32'hf, {28'h0, st_exp(m)});
    endtask
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        for (p = 0; p < 2; p++)
        begin
            pwr_req       <= p[0];
            ext_reset_pin <= 1'b1;
            ticks(2);
            ext_reset_pin <= 1'b0;
            ticks(p ? 4 : 1);
            chk("held", {31'h0, run_permit}, 32'h0);
            ticks(p ? 7 : 4);
            stat(p ? PMWC_MISSION : PMWC_BATTERY);
            apb(1'b0, A_CTRL, 32'h0);
            chk("config", rd_q, 32'h0);
            apb(1'b1, A_CTRL, 32'h300);
        end
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped", {31'h0, err_q}, 32'h1);
        c = $random(seed) & 32'hff;
        apb(1'b1, A_SEG, c);
        apb(1'b0, A_SEG, 32'h0);
        chk("segments", rd_q, c);
        pwr_req <= 1'b0;
        ticks(2);
        stat(PMWC_BATTERY);
        apb(1'b0, A_CTRL, 32'h0);
        chk("gated", rd_q & 32'h300, 32'h0);
        pwr_req <= 1'b1;
        ticks(4);
        chk("pll early", {31'h0, pll_ok}, 32'h0);
        ticks(7);
        stat(PMWC_MISSION);
        apb(1'b0, A_CTRL, 32'h0);
        chk("kept", rd_q, 32'h300);
        bat_req <= 1'b0;
        pwr_req <= 1'b0;
        ticks(2);
        stat(PMWC_HALT);
        bat_req <= 1'b1;
        pwr_req <= 1'b1;
        ticks(11);
        stat(PMWC_MISSION);
        apb(1'b0, A_CTRL, 32'h0);
        chk("cleared", rd_q, 32'h0);
        pwr_req <= 1'b0;
        ticks(2);
        for (p = 0; p < 2; p++)
        begin
            per = 1 + {$random(seed)} % 7;
            c   = 32'h4 | p << 3 | per << 4;
            apb(1'b1, A_STAT, 32'hf0);
            apb(1'b1, A_CTRL, c);
            ticks(3);
            apb(1'b1, A_CTRL, c | (p ? 1 : 2));
            stat(p ? PMWC_HALT : PMWC_DISPLAY);
            ticks(per * (p ? 8 : 4) - 3);
            chk("asleep", {31'h0, run_permit}, 32'h0);
            ticks(6);
            stat(PMWC_BATTERY);
            chk("timer flag", rd_q & 32'h30, 32'h20);
            apb(1'b0, A_CTRL, 32'h0);
            chk("disarmed", rd_q, 32'h0);
        end
        apb(1'b1, A_STAT, 32'hf0);
        apb(1'b1, A_CTRL, 32'h1);
        press_req <= 1'b1;
        ticks(400);
        press_req <= 1'b0;
        ticks(8);
        stat(PMWC_HALT);
        press_req <= 1'b1;
        ticks(2100);
        stat(PMWC_BATTERY);
        chk("button flag", rd_q & 32'h30, 32'h10);
        press_req <= 1'b0;
        apb(1'b1, A_CTRL, 32'h1);
        press_req <= 1'b1;
        ticks(2100);
        stat(PMWC_HALT);
        press_req <= 1'b0;
        pwr_req   <= 1'b1;
        ticks(11);
        pwr_req <= 1'b0;
        ticks(2);
        bat_req <= 1'b0;
        ticks(2);
        stat(PMWC_HALT);
        print_verdict();
    end
endmodule // pmwc_top_test
bind pmwc_top pmwc_checker pmwc_checker_inst (.*);
